// *** src/mcsc_params.svh ***
// constants of the multichip sync control block: offsets, field positions, resets, counts
// assumes it is included by bare name from the package and the block
`ifndef MCSC_PARAMS_SVH
`define MCSC_PARAMS_SVH

// register indices on the configuration port
`define MCSC_ADDR_DSC 5'h02
`define MCSC_ADDR_MSC 5'h03
`define MCSC_ADDR_STAT 5'h10

// multichip sync control word fields
`define MCSC_THR_MSB 31
`define MCSC_THR_LSB 27
`define MCSC_RXEN_BIT 26
`define MCSC_TXEN_BIT 25
`define MCSC_RXDLY_MSB 23
`define MCSC_RXDLY_LSB 19
`define MCSC_CHK_BIT 18
`define MCSC_SLAVE_BIT 16
`define MCSC_TXDLY_MSB 15
`define MCSC_TXDLY_LSB 11
// must-be-low bits 24 and 17 and the fields below 11 are not stored
`define MCSC_MSC_WMASK 32'hFEFD_F800
`define MCSC_MSC_RST 32'h0000_0000

// data sync control: only the slave sampling edge bit is kept here
`define MCSC_EDGE_BIT 1
`define MCSC_DSC_WMASK 16'h0002
`define MCSC_DSC_RST 16'h0000

// status word bits
`define MCSC_STAT_ERR_BIT 0
`define MCSC_STAT_LOCK_BIT 1

// delay line step and sync pulse spacing
`define MCSC_DLY_STEP_PS 12'h050
`define MCSC_SYNC_PERIOD 5'h10

`endif

// *** src/mcsc_pkg.sv ***
// types shared by the multichip sync control block
// assumes mcsc_params.svh is on the include path
package mcsc_pkg;
  `include "mcsc_params.svh"

  typedef struct packed {
    logic [4:0] thr;
    logic rx_en;
    logic tx_en;
    logic [4:0] rx_dly;
    logic auto_chk;
    logic slave;
    logic [4:0] tx_dly;
    logic edge_rise;
  } mcsc_cfg_t;

  typedef struct packed {
    logic [11:0] rx_ps;
    logic [11:0] tx_ps;
  } mcsc_dly_t;

  typedef enum logic [0:0] {CHK_IDLE, CHK_ARMED} mcsc_chk_t;
endpackage

// *** src/mcsc_top.sv ***
// multichip sync control: control word, data clock pin direction, sync pulse tx/rx, checks
// assumes the serial port logic presents register accesses on mclk_i; pins are asynchronous
`include "mcsc_params.svh"

// Operation
// RL1: five-bit correlation threshold sets how many good sync pulses declare lock.
// RL2: receive enable bit gates the sync receive logic; off after reset.
// RL3: transmit enable bit gates the sync pulse generator; off after reset.
// RL4: software writes zero to bits 24 and 17; they are never stored.
// RL5: incoming sync delay code gives 80 ps per step, all ones 2480 ps.
// RL6: check mode bit picks manual armed checking or automatic continuous checking.
// RL7: slave bit turns the data clock pin into an input; off after reset.
// RL8: in slave mode data is latched on the chosen external clock edge.
// RL9: software enables slave mode only with 4x or 8x interpolation.
// RL10: outgoing sync delay code gives 80 ps steps relative to reference clock.
// RL11: edge select 0 samples on falling edge, 1 on rising edge.
// RL12: outgoing delay code all ones adds 2480 ps.
module mcsc_top
  import mcsc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // data clock pin and data pins
  input wire logic data_clock_pin_i,
  output logic data_clock_pin_o,
  output logic data_clock_pin_oe_b_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] samp_data_o,
  output logic samp_valid_o,
  // sync chain pins
  input wire logic sync_in_i,
  output logic sync_out_o,
  // block side
  input wire logic check_req_i,
  output mcsc_pkg::mcsc_cfg_t cfg_o,
  output mcsc_pkg::mcsc_dly_t dly_o,
  output logic sync_rx_o,
  output logic sync_err_o,
  output logic sync_lock_o
);
  import mcsc_pkg::*;

  logic [31:0] msc_ff;
  logic [15:0] dsc_ff;
  mcsc_cfg_t cfg;
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic [DATA_W-1:0] dat_s1_ff, dat_s2_ff;
  logic syn_s1_ff, syn_s2_ff, syn_s3_ff;
  logic dclk_ff, oe_b_ff;
  logic [4:0] tx_cnt_ff, rx_cnt_ff, good_cnt_ff;
  logic seen_ff, rx_pulse, mismatch, take;
  mcsc_chk_t chk_ff;

  //////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      msc_ff <= `MCSC_MSC_RST;
      dsc_ff <= `MCSC_DSC_RST;
    end else if (reg_wr_i) begin
      // must-be-low bits are masked so a careless write cannot reach hidden logic; see RL4
      if (reg_addr_i == `MCSC_ADDR_MSC) begin
        msc_ff <= reg_wdata_i & `MCSC_MSC_WMASK;
      end
      if (reg_addr_i == `MCSC_ADDR_DSC) begin
        dsc_ff <= reg_wdata_i[15:0] & `MCSC_DSC_WMASK;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `MCSC_ADDR_MSC: reg_rdata_o <= msc_ff;
          `MCSC_ADDR_DSC: reg_rdata_o <= {16'h0000, dsc_ff};
          `MCSC_ADDR_STAT: reg_rdata_o <= {30'h0, sync_lock_o, sync_err_o};
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign cfg.thr = msc_ff[`MCSC_THR_MSB:`MCSC_THR_LSB];
  assign cfg.rx_en = msc_ff[`MCSC_RXEN_BIT];
  assign cfg.tx_en = msc_ff[`MCSC_TXEN_BIT];
  assign cfg.rx_dly = msc_ff[`MCSC_RXDLY_MSB:`MCSC_RXDLY_LSB];
  assign cfg.auto_chk = msc_ff[`MCSC_CHK_BIT];
  assign cfg.slave = msc_ff[`MCSC_SLAVE_BIT];
  assign cfg.tx_dly = msc_ff[`MCSC_TXDLY_MSB:`MCSC_TXDLY_LSB];
  assign cfg.edge_rise = dsc_ff[`MCSC_EDGE_BIT];
  assign cfg_o = cfg;

  // delay line settings for the analog cells, in ps
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      dly_o <= '0;
    end else begin
      dly_o.rx_ps <= 12'(cfg.rx_dly) * `MCSC_DLY_STEP_PS; // see RL5
      dly_o.tx_ps <= 12'(cfg.tx_dly) * `MCSC_DLY_STEP_PS; // see RL10, see RL12
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data clock pin and data capture

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      dat_s1_ff <= '0;
      dat_s2_ff <= '0;
      syn_s1_ff <= 1'b0;
      syn_s2_ff <= 1'b0;
      syn_s3_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= data_clock_pin_i;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      dat_s1_ff <= data_i;
      dat_s2_ff <= dat_s1_ff;
      syn_s1_ff <= sync_in_i;
      syn_s2_ff <= syn_s1_ff;
      syn_s3_ff <= syn_s2_ff;
    end
  end

  // master mode drives a half-rate clock; slave mode releases the pin
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      dclk_ff <= 1'b0;
      oe_b_ff <= 1'b0;
    end else begin
      dclk_ff <= ~dclk_ff;
      oe_b_ff <= cfg.slave; // see RL7
    end
  end
  assign data_clock_pin_o = dclk_ff;
  assign data_clock_pin_oe_b_o = oe_b_ff;

  // data and clock share the same two-stage delay so the chosen edge stays aligned
  always_comb begin
    if (cfg.slave) begin
      if (cfg.edge_rise) begin
        take = sclk_s2_ff & ~sclk_s3_ff; // see RL8
      end else begin
        take = ~sclk_s2_ff & sclk_s3_ff; // see RL11
      end
    end else begin
      take = ~dclk_ff;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      samp_data_o <= '0;
      samp_valid_o <= 1'b0;
    end else begin
      samp_valid_o <= take;
      if (take) begin
        samp_data_o <= dat_s2_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sync pulse generator

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      tx_cnt_ff <= 5'h00;
      sync_out_o <= 1'b0;
    end else begin
      tx_cnt_ff <= (tx_cnt_ff == `MCSC_SYNC_PERIOD - 5'h01) ? 5'h00 : tx_cnt_ff + 5'h01;
      sync_out_o <= cfg.tx_en && (tx_cnt_ff == 5'h00); // see RL3
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sync receiver, lock and error check

  assign rx_pulse = cfg.rx_en & syn_s2_ff & ~syn_s3_ff; // see RL2
  // a pulse off the expected spacing counts as a sync error
  assign mismatch = rx_pulse && seen_ff && (rx_cnt_ff != `MCSC_SYNC_PERIOD - 5'h01);

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rx_cnt_ff <= 5'h00;
      seen_ff <= 1'b0;
      good_cnt_ff <= 5'h00;
      sync_rx_o <= 1'b0;
    end else begin
      sync_rx_o <= rx_pulse;
      if (!cfg.rx_en) begin
        seen_ff <= 1'b0;
        good_cnt_ff <= 5'h00;
      end else if (rx_pulse) begin
        seen_ff <= 1'b1;
        // low thresholds lock sooner but trust fewer pulses; see RL1
        if (mismatch) begin
          good_cnt_ff <= 5'h00;
        end else if (seen_ff && good_cnt_ff != 5'h1F) begin
          good_cnt_ff <= good_cnt_ff + 5'h01;
        end
      end
      rx_cnt_ff <= rx_pulse ? 5'h00 : rx_cnt_ff + 5'h01;
    end
  end
  assign sync_lock_o = cfg.rx_en && seen_ff && (good_cnt_ff >= cfg.thr); // see RL1

  // manual mode looks only at the first pulse after a request
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      chk_ff <= CHK_IDLE;
    end else begin
      case (chk_ff)
        CHK_IDLE: if (check_req_i) chk_ff <= CHK_ARMED;
        CHK_ARMED: if (rx_pulse && seen_ff) chk_ff <= CHK_IDLE;
        default: chk_ff <= CHK_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sync_err_o <= 1'b0;
    end else if (mismatch && (cfg.auto_chk || chk_ff == CHK_ARMED)) begin
      sync_err_o <= 1'b1; // see RL6
    end else if (check_req_i) begin
      sync_err_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  thr_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL1
    (reg_wr_i && reg_addr_i == `MCSC_ADDR_MSC) |=> cfg_o.thr == $past(reg_wdata_i[31:27]))
    else $error("threshold not taken from write");
  rx_gated_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL2
    sync_rx_o |-> $past(cfg.rx_en) && !$past(syn_s3_ff))
    else $error("sync received while receiver off");
  tx_gated_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL3
    sync_out_o |-> $past(cfg.tx_en) && $past(tx_cnt_ff) == 5'h00)
    else $error("sync pulse while generator off");
  tx_spacing_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL3
    sync_out_o |=> !sync_out_o [*8])
    else $error("sync pulses too close");
  rx_delay_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL5
    1'b1 |=> dly_o.rx_ps == 12'($past(cfg.rx_dly)) * 12'h050)
    else $error("rx delay not 80 ps per step");
  tx_delay_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL10
    1'b1 |=> dly_o.tx_ps == 12'($past(cfg.tx_dly)) * 12'h050)
    else $error("tx delay not 80 ps per step");
  tx_delay_max_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL12
    cfg.tx_dly == 5'h1F |=> dly_o.tx_ps == 12'h9B0)
    else $error("tx delay all ones not 2480 ps");
  err_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL6
    $rose(sync_err_o) |-> $past(cfg.auto_chk) || $past(chk_ff) == CHK_ARMED)
    else $error("sync error set without check");
  pin_dir_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL7
    cfg.slave |=> data_clock_pin_oe_b_o)
    else $error("data clock pin driven in slave mode");
  rise_edge_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL8
    (samp_valid_o && $past(cfg.slave) && $past(cfg.edge_rise))
      |-> $past(sclk_s2_ff) && !$past(sclk_s3_ff))
    else $error("slave sample not on rising edge");
  fall_edge_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // see RL11
    (samp_valid_o && $past(cfg.slave) && !$past(cfg.edge_rise))
      |-> !$past(sclk_s2_ff) && $past(sclk_s3_ff))
    else $error("slave sample not on falling edge");

  slave_samp_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    cfg.slave && samp_valid_o);
  lock_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(sync_lock_o));
  manual_err_c: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    !cfg.auto_chk && $rose(sync_err_o));
endmodule

// *** test/mcsc_chain_model.sv ***
// far-side chip of the sync chain: one-cycle sync pulses every gap_i cycles
// assumes gap_i is at least 2 and that mclk_i is the block's own clock
module mcsc_chain_model (
  // clock and control
  input wire logic mclk_i,
  input wire logic run_i,
  input wire logic [5:0] gap_i,
  // sync pin
  output logic sync_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // a short gap_i gives off-spacing pulses, which the receiver must flag
  always_ff @(posedge mclk_i) begin
    if (!run_i) begin
      cnt_ff <= 6'h00;
    end else if (cnt_ff >= gap_i - 6'h01) begin
      cnt_ff <= 6'h00;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  // the line is always driven, low between pulses
  always_ff @(posedge mclk_i) begin
    sync_o <= run_i && (cnt_ff == 6'h00);
  end
endmodule

// *** test/tb.sv ***
// self-checking bench for mcsc_top: register port, data clock pin, sync chain
// assumes mcsc_pkg and mcsc_params.svh are compiled and on the include path
`include "mcsc_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcsc_pkg::*;
  logic mclk_i, rst_b_i, reg_wr_i, reg_rd_i, reg_rvalid_o, dclk_pin, dclk_wire, dclk_o, oe_b;
  logic samp_valid, sync_in, sync_out, sync_rx, sync_err, sync_lock, check_req, sync_run, lvl;
  logic [4:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic [15:0] data_in, samp_data;
  logic [5:0] gap;
  mcsc_cfg_t cfg;
  mcsc_dly_t dly;
  logic [31:0] exp_q[$];
  int bad_count, checked, vcnt, n, rcnt;

  // the pin level: the block drives it while oe_b is low
  assign dclk_wire = oe_b ? dclk_pin : dclk_o;

  mcsc_top uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .data_clock_pin_i(dclk_wire), .data_clock_pin_o(dclk_o),
    .data_clock_pin_oe_b_o(oe_b), .data_i(data_in), .samp_data_o(samp_data),
    .samp_valid_o(samp_valid), .sync_in_i(sync_in), .sync_out_o(sync_out),
    .check_req_i(check_req), .cfg_o(cfg), .dly_o(dly), .sync_rx_o(sync_rx),
    .sync_err_o(sync_err), .sync_lock_o(sync_lock));

  mcsc_chain_model peer (.mclk_i(mclk_i), .run_i(sync_run), .gap_i(gap), .sync_o(sync_in));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic final_report();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // read answers are taken off the queue in issue order
  always @(posedge mclk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0, "read data with no read pending");
      end else begin
        chk(reg_rdata_o, exp_q.pop_front(), "read data");
      end
    end
    if (samp_valid === 1'b1) begin
      vcnt++;
    end
    if (sync_rx === 1'b1) begin
      rcnt++;
    end
  end

  initial begin
    cyc(6000);
    bad_count++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 5'h00;
    reg_wdata_i = 32'h0000_0000;
    dclk_pin = 1'b0;
    data_in = 16'h0000;
    check_req = 1'b0;
    sync_run = 1'b0;
    gap = 6'h10;
    void'($urandom(26804));
    cyc(12);
    rst_b_i <= 1'b1;
    rd(5'h03, 32'h0000_0000);
    rd(5'h02, 32'h0000_0000);
    chk(oe_b, 1'b0, "pin not driven after reset");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      wr(5'h03, d);
      rd(5'h03, d & `MCSC_MSC_WMASK);
      chk({12'h000, cfg}, {12'h000, d[31:25], d[23:18], d[16:11], 1'b0}, "cfg");
      chk({8'h00, dly}, {8'h00, d[23:19] * 12'h050, d[15:11] * 12'h050}, "ps");
    end
    wr(5'h07, 32'hFFFF_FFFF);
    rd(5'h07, 32'h0000_0000);
    wr(5'h10, 32'hFFFF_FFFF);
    rd(5'h10, 32'h0000_0000);
    rd(5'h03, d & `MCSC_MSC_WMASK);
    wr(5'h02, 32'hFFFF_FFFF);
    rd(5'h02, 32'h0000_0002);
    // software keeps interpolation at 4x or 8x whenever slave mode is set
    wr(5'h03, 32'h0001_0000);
    cyc(2);
    chk(oe_b, 1'b1, "pin not released in slave mode");
    for (int e = 0; e < 2; e++) begin
      wr(5'h02, 32'(e) << 1);
      data_in <= 16'($urandom);
      cyc(8);
      vcnt = 0;
      dclk_pin <= 1'b1;
      cyc(8);
      chk(vcnt, e, "captures on rising edge");
      vcnt = 0;
      dclk_pin <= 1'b0;
      cyc(8);
      chk(vcnt, 1 - e, "captures on falling edge");
      chk(samp_data, data_in, "captured data");
    end
    wr(5'h03, 32'h0000_0000);
    n = 0;
    while (sync_out !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(n, 40, "sync pulse while generator off");
    chk(oe_b, 1'b0, "pin not driven in master mode");
    lvl = dclk_o;
    cyc(1);
    chk(dclk_o, !lvl, "data clock not toggling in master mode");
    wr(5'h03, 32'h0200_0000);
    n = 0;
    while (sync_out !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    cyc(1);
    n = 1;
    while (sync_out !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(n, 16, "sync pulse spacing");
    // threshold 2, receiver on, manual checking
    wr(5'h03, 32'h1400_0000);
    rcnt = 0;
    sync_run <= 1'b1;
    cyc(8);
    chk(sync_lock, 1'b0, "lock before threshold");
    cyc(112);
    chk(rcnt, 8, "received sync pulse count");
    rd(5'h10, 32'h0000_0002);
    gap <= 6'h0A;
    cyc(60);
    chk(sync_err, 1'b0, "error without armed check");
    check_req <= 1'b1;
    cyc(1);
    check_req <= 1'b0;
    cyc(40);
    chk(sync_err, 1'b1, "armed check missed bad spacing");
    wr(5'h03, 32'h1404_0000);
    gap <= 6'h10;
    cyc(40);
    check_req <= 1'b1;
    cyc(1);
    check_req <= 1'b0;
    cyc(40);
    chk(sync_err, 1'b0, "error not cleared");
    gap <= 6'h0A;
    cyc(40);
    chk(sync_err, 1'b1, "continuous check missed bad spacing");
    wr(5'h03, 32'h0000_0000);
    cyc(40);
    chk(sync_lock, 1'b0, "lock kept with receiver off");
    rcnt = 0;
    cyc(40);
    chk(rcnt, 0, "sync received with receiver off");
    sync_run <= 1'b0;
    cyc(4);
    chk(exp_q.size(), 32'h0, "reads left unanswered");
    final_report();
  end
endmodule
